// File: hw/csor_regs.v
// Purpose: bank of 16-bit parameter words for outputs and link status
// Assumes: word port with index, write strobe and read strobe on core clock
// Notes: reads answer one cycle after the read strobe
//
// Summary of operation
// RL1: Digital output word bits 0..2 drive outputs one to three.
// RL2: Analog output is a 10-bit code, 0 is zero, 1023 full scale.
// RL3: Serial status reads 0 when the accessory is absent.
// RL4: Serial status reads 1 when the accessory is installed and detected.
// RL5: Serial status reads 2 on timeout alarm or fault while active.
// RL6: Received-telegram counter counts every received telegram.
// RL7: Transmitted-telegram counter counts every transmitted telegram.
// RL8: Count received messages with a bad CRC or checksum.
// RL9: Separately count received bytes with other communication errors.
// RL10: All serial counters are 16-bit and wrap to zero after 65535.
// RL11: Module ident reads 0 if absent, else a protocol code up to 25.
// RL12: Module state reads 0 awaiting setup, 1 while initialising.
// RL13: Module state 2 without master contact, 3 master idle.
// RL14: Module state 4 data exchange; 5 and 6 never reported.
// RL15: Module state 7 on serious error, 8 on access error.
// RL16: Config status bits 0..2: init, firmware download, guided start-up.
// RL17: Config status bits 3..5: incompatible, reset needed, panel copy.
// RL18: Motor start refused while any configuration condition is active.
// RL19: Enter configuration hold on any parameter conflict.
// RL20: Control bit 0 written 1 aborts guided start-up; 0 leaves it.
// RL21: Reserved bits read zero and ignore writes.
`include "csor_map.vh"

module csor_regs (
    input wire i_core_clk,
    input wire i_sys_rst,
    // Word access port
    input wire [3:0] i_reg_idx,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [15:0] i_reg_wdata,
    output reg [15:0] o_reg_rdata,
    output reg o_reg_rvalid,
    output reg o_reg_err,
    // Serial accessory, from outside the clock domain
    input wire i_ser_present,
    input wire i_serial_timeout_alarm,
    input wire i_serial_timeout_fault,
    // Serial events, one-cycle pulses on core clock
    input wire i_ser_rx_telegram,
    input wire i_ser_tx_telegram,
    input wire i_ser_check_error,
    input wire i_ser_byte_error,
    // Fieldbus module
    input wire i_fb_present,
    input wire [4:0] i_fb_ident,
    input wire i_fb_cfg_done,
    input wire i_fb_init_done,
    input wire i_fb_master_link,
    input wire i_fb_master_run,
    input wire i_fb_except,
    input wire i_fb_access_err,
    // Configuration-mode conditions
    input wire i_sys_init,
    input wire i_fw_download,
    input wire i_guided_startup,
    input wire i_reset_needed,
    input wire i_panel_copy_function,
    input wire i_param_conflict,
    input wire [15:0] i_motor_i_limit,
    input wire [15:0] i_starter_i_rated,
    input wire i_start_req,
    // Outputs to the plant
    output reg o_digital_output_one,
    output reg o_digital_output_two,
    output reg o_digital_output_three,
    output reg [9:0] o_analog_output,
    output reg o_motor_start,
    output reg o_config_hold,
    output reg o_abort_startup
);

// ****************************************
// Pin synchronisers
// ****************************************
wire [2:0] ser_pins;
csor_sync #(.W(3)) u_sync (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_ser_present, i_serial_timeout_alarm,
        i_serial_timeout_fault}),
    .o_sync(ser_pins)
);
wire ser_present = ser_pins[2];
wire ser_timeout = ser_pins[1] | ser_pins[0];

// ****************************************
// Serial counters
// ****************************************
wire [15:0] rx_cnt;
wire [15:0] tx_cnt;
wire [15:0] chk_cnt;
wire [15:0] byte_cnt;

// RL6: received telegrams
csor_counter u_rx (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_event(i_ser_rx_telegram),
    .o_count(rx_cnt)
);
// RL7: transmitted telegrams
csor_counter u_tx (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_event(i_ser_tx_telegram),
    .o_count(tx_cnt)
);
// RL8: bad check field
csor_counter u_chk (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_event(i_ser_check_error),
    .o_count(chk_cnt)
);
// RL9: other byte errors
csor_counter u_byte (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_event(i_ser_byte_error),
    .o_count(byte_cnt)
);

// ****************************************
// Serial interface status
// ****************************************
reg [1:0] ser_stat_ff;
reg [1:0] nxt_ser_stat;

always @* begin
    // RL3: accessory absent
    if (!ser_present) begin
        nxt_ser_stat = `CSOR_SER_OFF;
    // RL5: timeout while active
    end else if (ser_timeout) begin
        nxt_ser_stat = `CSOR_SER_TIMEOUT;
    // RL4: installed and detected
    end else begin
        nxt_ser_stat = `CSOR_SER_ON;
    end
end

always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
        ser_stat_ff <= `CSOR_SER_OFF;
    end else begin
        ser_stat_ff <= nxt_ser_stat;
    end
end

// ****************************************
// Fieldbus module identification and state
// ****************************************
reg [4:0] fb_ident_ff;
reg [3:0] fb_state_ff;
reg [3:0] nxt_fb_state;

// RL11: absent or over-range reads zero
always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
        fb_ident_ff <= `CSOR_FB_ID_NONE;
    end else if (!i_fb_present || i_fb_ident > `CSOR_FB_ID_MAX) begin
        fb_ident_ff <= `CSOR_FB_ID_NONE;
    end else begin
        fb_ident_ff <= i_fb_ident;
    end
end

always @* begin
    nxt_fb_state = fb_state_ff;
    // RL15: error states take priority
    if (!i_fb_present) begin
        nxt_fb_state = `CSOR_FB_ST_SETUP;
    end else if (i_fb_access_err) begin
        nxt_fb_state = `CSOR_FB_ST_ACCESS;
    end else if (i_fb_except) begin
        nxt_fb_state = `CSOR_FB_ST_EXCEPT;
    end else begin
        case (fb_state_ff)
            // RL12: automatic setup then init
            `CSOR_FB_ST_SETUP: begin
                if (i_fb_cfg_done) begin
                    nxt_fb_state = `CSOR_FB_ST_INIT;
                end
            end
            `CSOR_FB_ST_INIT: begin
                if (i_fb_init_done) begin
                    nxt_fb_state = `CSOR_FB_ST_WAIT;
                end
            end
            // RL13: waiting for or idle with master
            // RL14: exchanging data
            `CSOR_FB_ST_WAIT, `CSOR_FB_ST_IDLE,
            `CSOR_FB_ST_ACTIVE: begin
                if (!i_fb_master_link) begin
                    nxt_fb_state = `CSOR_FB_ST_WAIT;
                end else if (i_fb_master_run) begin
                    nxt_fb_state = `CSOR_FB_ST_ACTIVE;
                end else begin
                    nxt_fb_state = `CSOR_FB_ST_IDLE;
                end
            end
            // Error states leave only through reinitialisation
            `CSOR_FB_ST_EXCEPT, `CSOR_FB_ST_ACCESS: begin
                nxt_fb_state = `CSOR_FB_ST_SETUP;
            end
            default: begin
                nxt_fb_state = `CSOR_FB_ST_SETUP;
            end
        endcase
    end
end

always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
        fb_state_ff <= `CSOR_FB_ST_SETUP;
    end else begin
        fb_state_ff <= nxt_fb_state;
    end
end

// ****************************************
// Configuration mode
// ****************************************
reg [5:0] cfg_stat_ff;
reg cfg_ctrl_ff;
wire cfg_wr = i_reg_wr && (i_reg_idx == `CSOR_IDX_CFG_CTRL);
// Product fits 20 bits, so no overflow on large ratings
wire [19:0] limit_max = {4'h0, i_starter_i_rated} *
    {16'h0000, `CSOR_MOTOR_I_RATIO};
// RL19: parameter conflict detection
wire incompat = i_param_conflict || ({4'h0, i_motor_i_limit} > limit_max);

// RL16: progress bits
// RL17: fault and copy bits
always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
        cfg_stat_ff <= 6'h00;
    end else begin
        cfg_stat_ff <= {i_panel_copy_function, i_reset_needed, incompat,
            i_guided_startup, i_fw_download, i_sys_init};
    end
end

// RL20: abort bit, held until rewritten
always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
        cfg_ctrl_ff <= 1'b0;
    end else if (cfg_wr) begin
        cfg_ctrl_ff <= i_reg_wdata[`CSOR_CFG_CTRL_ABORT];
    end
end

// ****************************************
// Output words
// ****************************************
reg [2:0] dig_out_ff;
reg [9:0] ana_out_ff;

// RL21: reserved bits not stored
always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
        dig_out_ff <= 3'h0;
        ana_out_ff <= 10'h000;
    end else if (i_reg_wr) begin
        if (i_reg_idx == `CSOR_IDX_DIG_OUT) begin
            dig_out_ff <= i_reg_wdata[2:0];
        end
        if (i_reg_idx == `CSOR_IDX_ANA_OUT) begin
            ana_out_ff <= i_reg_wdata[9:0];
        end
    end
end

// RL1: drive digital outputs
// RL2: linear analog code
// RL18: refuse start in configuration mode
always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
        o_digital_output_one <= 1'b0;
        o_digital_output_two <= 1'b0;
        o_digital_output_three <= 1'b0;
        o_analog_output <= 10'h000;
        o_motor_start <= 1'b0;
        o_config_hold <= 1'b0;
        o_abort_startup <= 1'b0;
    end else begin
        o_digital_output_one <= dig_out_ff[0];
        o_digital_output_two <= dig_out_ff[1];
        o_digital_output_three <= dig_out_ff[2];
        o_analog_output <= ana_out_ff;
        o_motor_start <= i_start_req && (cfg_stat_ff == 6'h00);
        o_config_hold <= (cfg_stat_ff != 6'h00);
        o_abort_startup <= cfg_ctrl_ff & cfg_stat_ff[2];
    end
end

// ****************************************
// Read port
// ****************************************
reg [15:0] rd_mux;
reg rd_bad;

// RL21: reserved bits read zero
always @* begin
    rd_bad = 1'b0;
    case (i_reg_idx)
        `CSOR_IDX_DIG_OUT: rd_mux = {13'h0000, dig_out_ff};
        `CSOR_IDX_ANA_OUT: rd_mux = {6'h00, ana_out_ff};
        `CSOR_IDX_SER_STAT: rd_mux = {14'h0000, ser_stat_ff};
        `CSOR_IDX_SER_RX: rd_mux = rx_cnt;
        `CSOR_IDX_SER_TX: rd_mux = tx_cnt;
        `CSOR_IDX_SER_CHK: rd_mux = chk_cnt;
        `CSOR_IDX_SER_BYTE: rd_mux = byte_cnt;
        `CSOR_IDX_FB_IDENT: rd_mux = {11'h000, fb_ident_ff};
        `CSOR_IDX_FB_STATE: rd_mux = {12'h000, fb_state_ff};
        `CSOR_IDX_CFG_STAT: rd_mux = {10'h000, cfg_stat_ff};
        `CSOR_IDX_CFG_CTRL: rd_mux = {15'h0000, cfg_ctrl_ff};
        default: begin
            rd_mux = 16'h0000;
            rd_bad = 1'b1;
        end
    endcase
end

always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
        o_reg_rdata <= 16'h0000;
        o_reg_rvalid <= 1'b0;
        o_reg_err <= 1'b0;
    end else begin
        o_reg_rvalid <= i_reg_rd;
        o_reg_err <= (i_reg_rd | i_reg_wr) & rd_bad;
        if (i_reg_rd) begin
            o_reg_rdata <= rd_mux;
        end
    end
end

endmodule

// File: inc/csor_map.vh
// Purpose: constants of the communication status and output word bank
// Assumes: 16-bit parameter words addressed by a small word index
// Notes: indices are grouped by function
`ifndef CSOR_MAP_VH
`define CSOR_MAP_VH

// ****************************************
// Word indices
// ****************************************
`define CSOR_IDX_DIG_OUT 4'h0
`define CSOR_IDX_ANA_OUT 4'h1
`define CSOR_IDX_SER_STAT 4'h2
`define CSOR_IDX_SER_RX 4'h3
`define CSOR_IDX_SER_TX 4'h4
`define CSOR_IDX_SER_CHK 4'h5
`define CSOR_IDX_SER_BYTE 4'h6
`define CSOR_IDX_FB_IDENT 4'h7
`define CSOR_IDX_FB_STATE 4'h8
`define CSOR_IDX_CFG_STAT 4'h9
`define CSOR_IDX_CFG_CTRL 4'ha

// ****************************************
// Fields and codes
// ****************************************
`define CSOR_DIG_OUT_MASK 16'h0007
`define CSOR_ANA_OUT_MASK 16'h03ff
`define CSOR_CFG_CTRL_MASK 16'h0001
`define CSOR_CFG_CTRL_ABORT 0
`define CSOR_SER_OFF 2'h0
`define CSOR_SER_ON 2'h1
`define CSOR_SER_TIMEOUT 2'h2
`define CSOR_FB_ID_NONE 5'h00
`define CSOR_FB_ID_MAX 5'h19
`define CSOR_FB_ST_SETUP 4'h0
`define CSOR_FB_ST_INIT 4'h1
`define CSOR_FB_ST_WAIT 4'h2
`define CSOR_FB_ST_IDLE 4'h3
`define CSOR_FB_ST_ACTIVE 4'h4
`define CSOR_FB_ST_EXCEPT 4'h7
`define CSOR_FB_ST_ACCESS 4'h8
`define CSOR_MOTOR_I_RATIO 4'h5
`define CSOR_RST_WORD 16'h0000

`endif

// File: hw/csor_counter.v
// Purpose: cyclic 16-bit event counter
// Assumes: event input is a one-cycle pulse on the core clock
// Notes: wraps from 16'hffff to zero by natural overflow
`include "csor_map.vh"

module csor_counter (
    input wire i_core_clk,
    input wire i_sys_rst,
    input wire i_event,
    output wire [15:0] o_count
);

reg [15:0] count_ff;

// RL10: wraps after 65535
always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
        count_ff <= `CSOR_RST_WORD;
    end else if (i_event) begin
        count_ff <= count_ff + 16'h0001;
    end
end

assign o_count = count_ff;

endmodule

// File: hw/csor_sync.v
// Purpose: two-flop synchroniser for a bus of levels
// Assumes: each bit is an independent level from outside the clock
// Notes: first stage feeds only the second stage
module csor_sync #(
    parameter W = 1
) (
    input wire i_core_clk,
    input wire i_sys_rst,
    input wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);

reg [W-1:0] meta_ff;
reg [W-1:0] sync_ff;

always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
        meta_ff <= {W{1'b0}};
        sync_ff <= {W{1'b0}};
    end else begin
        meta_ff <= i_async;
        sync_ff <= meta_ff;
    end
end

assign o_sync = sync_ff;

endmodule

// File: testbench/csor_regs_assertions.sv
// Purpose: port checker of the word bank
// Assumes: fixed latencies, two cycles for derived outputs
// Notes: bound to every instance of the bank
module csor_regs_chk (
    input wire i_core_clk,
    input wire i_sys_rst,
    input wire [3:0] i_reg_idx,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [15:0] i_reg_wdata,
    input wire [15:0] o_reg_rdata,
    input wire o_reg_rvalid,
    input wire o_reg_err,
    input wire i_guided_startup,
    input wire i_param_conflict,
    input wire o_digital_output_one,
    input wire [9:0] o_analog_output,
    input wire o_motor_start,
    input wire o_config_hold,
    input wire o_abort_startup
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);
    dig_out_a: assert property (i_reg_wr && i_reg_idx == 4'h0 |-> ##2
        o_digital_output_one == $past(i_reg_wdata[0], 2)) else $error("dout");
    ana_out_a: assert property (i_reg_wr && i_reg_idx == 4'h1 |-> ##2
        o_analog_output == $past(i_reg_wdata[9:0], 2)) else $error("aout");
    unmapped_rd_a: assert property (i_reg_rd && i_reg_idx > 4'ha |=>
        o_reg_rvalid && o_reg_err && o_reg_rdata == 16'h0000)
        else $error("unmapped read");
    unmapped_wr_a: assert property (i_reg_wr && !i_reg_rd &&
        i_reg_idx > 4'ha |=> o_reg_err && !o_reg_rvalid)
        else $error("unmapped write");
    ctrl_rsvd_a: assert property (i_reg_rd && i_reg_idx == 4'ha |=>
        o_reg_rdata[15:1] == 15'h0000) else $error("control reserved");
    start_block_a: assert property (o_config_hold |-> !o_motor_start)
        else $error("start while held");
    conflict_hold_a: assert property (i_param_conflict |-> ##2
        o_config_hold) else $error("no hold on conflict");
    abort_gate_a: assert property (!i_guided_startup |-> ##2
        !o_abort_startup) else $error("abort outside start-up");
    abort_set_a: assert property (i_reg_wr && i_reg_idx == 4'ha &&
        i_reg_wdata[0] && i_guided_startup |-> ##2 o_abort_startup)
        else $error("abort missing");
    state_code_a: assert property (i_reg_rd && i_reg_idx == 4'h8 |=>
        o_reg_rdata < 16'h0005 || o_reg_rdata == 16'h0007 ||
        o_reg_rdata == 16'h0008) else $error("module state code");
    cover property (i_reg_wr && i_reg_idx == 4'h0 && i_reg_wdata[0]);
    cover property (i_param_conflict ##2 o_config_hold);
    cover property (o_abort_startup);
endmodule

bind csor_regs csor_regs_chk u_regs_chk (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_reg_idx(i_reg_idx),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .o_reg_err(o_reg_err), .i_guided_startup(i_guided_startup),
    .i_param_conflict(i_param_conflict),
    .o_digital_output_one(o_digital_output_one),
    .o_analog_output(o_analog_output), .o_motor_start(o_motor_start),
    .o_config_hold(o_config_hold), .o_abort_startup(o_abort_startup)
);

// File: testbench/csor_host.sv
// Purpose: host model driving the word port of the bank
// Assumes: strobes are one-cycle pulses launched at falling edges
// Notes: write data is inverted when released, so stale data never helps
module csor_host (
    input wire clk,
    output reg [3:0] o_idx,
    output reg o_wr,
    output reg o_rd,
    output reg [15:0] o_wdata,
    input wire [15:0] i_rdata,
    input wire i_rvalid,
    input wire i_err
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_idx = 4'h0;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_wdata = 16'h0000;
    end
    // ****************************************
    // Word access tasks
    // ****************************************
    // single word writes at any index
    task wr_word(input [3:0] a, input [15:0] d);
        begin
            @(negedge clk);
            o_idx = a;
            o_wdata = d;
            o_wr = 1'b1;
            @(negedge clk);
            o_wr = 1'b0;
            o_wdata = ~d;
        end
    endtask
    task rd_word(input [3:0] a, output [15:0] d, output e);
        integer n;
        begin
            @(negedge clk);
            o_idx = a;
            o_rd = 1'b1;
            @(negedge clk);
            o_rd = 1'b0;
            n = 0;
            // Valid and error stand one cycle, looked at while settled
            while (i_rvalid !== 1'b1 && n < 4) begin
                @(negedge clk);
                n = n + 1;
            end
            d = i_rdata;
            e = i_err;
            // Missing answer must never look like good data
            if (i_rvalid !== 1'b1) begin
                d = 16'hxxxx;
            end
        end
    endtask
endmodule

// File: testbench/comm_status_output_regs_tb_top.sv
// Purpose: self-checking bench of the word bank
// Assumes: host model owns the word port
// Notes: receive counter is run past its wrap point, about 66k cycles
module comm_status_output_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [2:0] ser = 3'h0;
    reg [3:0] ev = 4'h0;
    reg [5:0] fbl = 6'h00;
    reg fbp = 1'b0;
    reg [4:0] fid = 5'h00;
    reg [5:0] cfg = 6'h00;
    reg [15:0] lim = 16'h0000;
    reg [15:0] rat = 16'h0064;
    reg sreq = 1'b1;
    wire [3:0] idx;
    wire wr, rd, rv, err, d1, d2, d3, mst, hold, abrt;
    wire [15:0] wd, rdat;
    wire [9:0] ao;
    integer seed = 19694;
    integer miscompares = 0;
    integer comparisons = 0;
    integer cyc = 0;
    integer i;
    reg [15:0] d, ntx, nck, nby;
    reg er;
    always #2.5 clk = ~clk;
    csor_host host (.clk(clk), .o_idx(idx), .o_wr(wr), .o_rd(rd),
        .o_wdata(wd), .i_rdata(rdat), .i_rvalid(rv), .i_err(err));
    csor_regs uut (.i_core_clk(clk), .i_sys_rst(rst), .i_reg_idx(idx),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wd), .o_reg_rdata(rdat),
        .o_reg_rvalid(rv), .o_reg_err(err), .i_ser_present(ser[2]),
        .i_serial_timeout_alarm(ser[1]), .i_serial_timeout_fault(ser[0]),
        .i_ser_rx_telegram(ev[3]), .i_ser_tx_telegram(ev[2]),
        .i_ser_check_error(ev[1]), .i_ser_byte_error(ev[0]),
        .i_fb_present(fbp), .i_fb_ident(fid), .i_fb_cfg_done(fbl[5]),
        .i_fb_init_done(fbl[4]), .i_fb_master_link(fbl[3]),
        .i_fb_master_run(fbl[2]), .i_fb_except(fbl[1]),
        .i_fb_access_err(fbl[0]), .i_sys_init(cfg[0]), .i_fw_download(cfg[1]),
        .i_guided_startup(cfg[2]), .i_param_conflict(cfg[3]),
        .i_reset_needed(cfg[4]), .i_panel_copy_function(cfg[5]),
        .i_motor_i_limit(lim), .i_starter_i_rated(rat), .i_start_req(sreq),
        .o_digital_output_one(d1), .o_digital_output_two(d2),
        .o_digital_output_three(d3), .o_analog_output(ao),
        .o_motor_start(mst), .o_config_hold(hold), .o_abort_startup(abrt));
    // ****************************************
    // Check and access helpers
    // ****************************************
    task end_of_test;
        begin
            if (miscompares == 0 && comparisons > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task chk(input string n, input [15:0] x, input [15:0] g);
        begin
            comparisons = comparisons + 1;
            if (g !== x) begin
                miscompares = miscompares + 1;
                $display("ERROR %s expected %h seen %h", n, x, g);
            end
        end
    endtask
    task rdc(input string n, input [3:0] a, input [15:0] x);
        reg [15:0] g;
        begin
            host.rd_word(a, g, er);
            chk(n, x, g);
        end
    endtask
    task sset(input [2:0] v, input [15:0] x);
        begin
            ser = v;
            repeat (4) @(negedge clk);
            rdc("serial status", 4'h2, x);
        end
    endtask
    task fst(input [5:0] v, input [15:0] x);
        begin
            fbl = v;
            repeat (3) @(negedge clk);
            rdc("module state", 4'h8, x);
        end
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 90000) begin
            miscompares = miscompares + 1;
            end_of_test;
        end
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        for (i = 0; i < 11; i = i + 1)
            rdc("reset word", i[3:0], 16'h0000);
        for (i = 0; i < 8; i = i + 1) begin
            d = (i == 0) ? 16'hffff : $random(seed);
            host.wr_word(4'h0, d);
            host.wr_word(4'h1, d);
            repeat (2) @(negedge clk);
            chk("dout", {13'h0, d[2:0]}, {13'h0, d3, d2, d1});
            chk("aout", {6'h0, d[9:0]}, {6'h0, ao});
            rdc("dout word", 4'h0, d & 16'h0007);
            rdc("aout word", 4'h1, d & 16'h03ff);
        end
        sset(3'h4, 16'h0001);
        sset(3'h6, 16'h0002);
        sset(3'h5, 16'h0002);
        sset(3'h0, 16'h0000);
        ntx = 16'h0000;
        nck = 16'h0000;
        nby = 16'h0000;
        for (i = 0; i < 300; i = i + 1) begin
            @(negedge clk);
            d = $random(seed);
            ev = {1'b0, d[2:0]};
            ntx = ntx + d[2];
            nck = nck + d[1];
            nby = nby + d[0];
        end
        @(negedge clk);
        ev = 4'h0;
        host.wr_word(4'h4, 16'hffff);
        rdc("tx count", 4'h4, ntx);
        rdc("check errors", 4'h5, nck);
        rdc("byte errors", 4'h6, nby);
        ev = 4'h8;
        repeat (65538) @(negedge clk);
        ev = 4'h0;
        rdc("rx wrap", 4'h3, 16'h0002);
        fid = 5'h10;
        repeat (3) @(negedge clk);
        rdc("ident absent", 4'h7, 16'h0000);
        fbp = 1'b1;
        repeat (3) @(negedge clk);
        rdc("ident", 4'h7, 16'h0010);
        fid = 5'h19;
        repeat (3) @(negedge clk);
        rdc("ident max", 4'h7, 16'h0019);
        fid = 5'h1a;
        repeat (3) @(negedge clk);
        rdc("ident over range", 4'h7, 16'h0000);
        fst(6'h00, 16'h0000);
        fst(6'h20, 16'h0001);
        fst(6'h30, 16'h0002);
        fst(6'h38, 16'h0003);
        fst(6'h3c, 16'h0004);
        fst(6'h3e, 16'h0007);
        fst(6'h3f, 16'h0008);
        fst(6'h00, 16'h0000);
        for (i = 0; i < 6; i = i + 1) begin
            cfg = 6'h01 << i;
            repeat (3) @(negedge clk);
            rdc("config status", 4'h9, 16'h0001 << i);
            chk("hold", 16'h0001, {15'h0, hold});
            chk("start", 16'h0000, {15'h0, mst});
        end
        cfg = 6'h00;
        lim = 16'h01f4;
        repeat (3) @(negedge clk);
        chk("start free", 16'h0001, {15'h0, mst});
        lim = 16'h01f5;
        repeat (3) @(negedge clk);
        rdc("current conflict", 4'h9, 16'h0008);
        lim = 16'h0000;
        cfg = 6'h04;
        host.wr_word(4'ha, 16'hffff);
        repeat (2) @(negedge clk);
        chk("abort", 16'h0001, {15'h0, abrt});
        rdc("control word", 4'ha, 16'h0001);
        host.wr_word(4'ha, 16'h0000);
        repeat (2) @(negedge clk);
        chk("no abort", 16'h0000, {15'h0, abrt});
        for (i = 11; i < 16; i = i + 1) begin
            host.wr_word(i[3:0], 16'hffff);
            rdc("unmapped", i[3:0], 16'h0000);
            chk("unmapped err", 16'h0001, {15'h0, er});
        end
        end_of_test;
    end
endmodule
